/* hdl/acs_map.vh */
// Constants for the atomic compare-and-swap execution unit.
// Assumes a 32-bit byte-addressed physical space with one RAM window.
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// ************************************************************
// Physical RAM window used for synchronisable locations
// ************************************************************
`define ACS_RAM_BASE      32'h2000_0000
`define ACS_RAM_LIMIT     32'h2fff_ffff

// ************************************************************
// Exception codes reported on a fault
// ************************************************************
`define ACS_EXC_NONE      3'h0
`define ACS_EXC_TLB_STORE 3'h1
`define ACS_EXC_MODIFY    3'h2
`define ACS_EXC_BUS       3'h3
`define ACS_EXC_ADDR      3'h4

// ************************************************************
// Result values written back to the new-value register
// ************************************************************
`define ACS_RESULT_OK     32'h0000_0001
`define ACS_RESULT_FAIL   32'h0000_0000

// ************************************************************
// Start-up entry point in read-only memory
// ************************************************************
`define ACS_STARTUP_ENTRY 32'h1fc0_0000
`define ACS_CPU_ID_W      4

`endif

/* hdl/acs_unit.v */
// Atomic compare-and-swap execution unit with processor start-up request.
// Assumes a memory port with request/grant and a lock held across the pair.
// Contract
// - Read word at address, compare with expected
// - Match: store new value, return one
// - Mismatch: return zero, no store
// - Read and write locked as one operation
// - Only physical RAM addresses are eligible
// - Outside RAM: fail with zero, no access
// - Faults: store miss, modify, bus, address
// - Start-up service resets selected processor
`timescale 1ns/1ps
`include "acs_map.vh"

module acs_unit
(
	// Clock and reset.
	input  wire        clock,
	input  wire        nrst,
	// Instruction request from the pipeline.
	input  wire        start,
	input  wire [31:0] address_operand_reg,
	input  wire [31:0] expected_value_reg,
	input  wire [31:0] new_value_reg,
	// Translation result for the store side, valid with start.
	input  wire        store_translation_miss,
	input  wire        page_not_writable,
	// Memory port.
	output reg         mem_req,
	output reg         mem_we,
	output reg         mem_lock,
	output reg  [31:0] mem_addr,
	output reg  [31:0] mem_wdata,
	input  wire        mem_ack,
	input  wire        mem_err,
	input  wire [31:0] mem_rdata,
	// Completion toward the pipeline.
	output reg         done,
	output reg  [31:0] result,
	output reg         fault,
	output reg  [2:0]  fault_code,
	output reg         busy,
	// Processor start-up service.
	input  wire        startup_req,
	input  wire [`ACS_CPU_ID_W-1:0] startup_cpu_id,
	output reg  [15:0] cpu_reset,
	output reg  [31:0] startup_entry
);

	// ************************************************************
	// State encoding
	// ************************************************************
	localparam [3:0] ST_IDLE  = 4'h1;
	localparam [3:0] ST_READ  = 4'h2;
	localparam [3:0] ST_WRITE = 4'h4;
	localparam [3:0] ST_END   = 4'h8;

	reg [3:0]  state;      // Current sequencer state.
	reg [31:0] hold_new;   // New value captured at start.
	reg [31:0] hold_exp;   // Expected value captured at start.

	// Address checks on the incoming operand.
	wire in_ram    = (address_operand_reg >= `ACS_RAM_BASE) &&
	                 (address_operand_reg <= `ACS_RAM_LIMIT);
	wire unaligned = (address_operand_reg[1:0] != 2'h0);

	// ************************************************************
	// Compare-and-swap sequencer
	// ************************************************************
	// The lock is raised with the read and dropped only after the store, a bus error in either phase
	// or the mismatch, so the memory system can refuse others between.
	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			state      <= ST_IDLE;
			hold_new   <= 32'h0000_0000;
			hold_exp   <= 32'h0000_0000;
			mem_req    <= 1'b0;
			mem_we     <= 1'b0;
			mem_lock   <= 1'b0;
			mem_addr   <= 32'h0000_0000;
			mem_wdata  <= 32'h0000_0000;
			done       <= 1'b0;
			result     <= 32'h0000_0000;
			fault      <= 1'b0;
			fault_code <= `ACS_EXC_NONE;
			busy       <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			case (state)
			ST_IDLE:
			begin
				fault <= 1'b0;
				if (start)
				begin
					// Faults are checked first, alignment ahead of translation.
					if (unaligned)
					begin
						fault      <= 1'b1;
						fault_code <= `ACS_EXC_ADDR;
						done       <= 1'b1;
					end
					else if (store_translation_miss)
					begin
						fault      <= 1'b1;
						fault_code <= `ACS_EXC_TLB_STORE;
						done       <= 1'b1;
					end
					else if (page_not_writable)
					begin
						fault      <= 1'b1;
						fault_code <= `ACS_EXC_MODIFY;
						done       <= 1'b1;
					end
					else if (!in_ram)
					begin
						// Non-RAM targets fail without touching the bus.
						result     <= `ACS_RESULT_FAIL;
						fault_code <= `ACS_EXC_NONE;
						done       <= 1'b1;
					end
					else
					begin
						hold_new   <= new_value_reg;
						hold_exp   <= expected_value_reg;
						mem_addr   <= address_operand_reg;
						mem_req    <= 1'b1;
						mem_we     <= 1'b0;
						mem_lock   <= 1'b1;
						fault_code <= `ACS_EXC_NONE;
						busy       <= 1'b1;
						state      <= ST_READ;
					end
				end
			end
			ST_READ:
			begin
				if (mem_err)
				begin
					// Only the code is kept here; the fault flag rises with done.
					mem_req    <= 1'b0;
					mem_lock   <= 1'b0;
					fault_code <= `ACS_EXC_BUS;
					state      <= ST_END;
				end
				else if (mem_ack)
				begin
					if (mem_rdata == hold_exp)
					begin
						mem_we    <= 1'b1;
						mem_wdata <= hold_new;
						state     <= ST_WRITE;
					end
					else
					begin
						mem_req  <= 1'b0;
						mem_lock <= 1'b0;
						result   <= `ACS_RESULT_FAIL;
						state    <= ST_END;
					end
				end
			end
			ST_WRITE:
			begin
				if (mem_err || mem_ack)
				begin
					mem_req  <= 1'b0;
					mem_we   <= 1'b0;
					mem_lock <= 1'b0;
					if (mem_err)
					begin
						// The store was refused, so the word is left as it was.
						fault_code <= `ACS_EXC_BUS;
					end
					else
					begin
						result <= `ACS_RESULT_OK;
					end
					state <= ST_END;
				end
			end
			ST_END:
			begin
				// A bus error seen in either phase is reported together with done,
				// so the pipeline never sees a fault without a completion.
				fault <= (fault_code == `ACS_EXC_BUS);
				done  <= 1'b1;
				busy  <= 1'b0;
				state <= ST_IDLE;
			end
			default:
			begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// ************************************************************
	// Processor start-up service
	// ************************************************************
	// A reset as long as the request, one cycle behind it, goes to the chosen processor; its entry
	// point is a fixed ROM address presented alongside.
	// One bit per processor; the shift keeps the decode at sixteen bits.
	wire [15:0] id_onehot = 16'h0001 << startup_cpu_id;

	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1)
		begin : g_rst
			always @(posedge clock or negedge nrst)
			begin
				if (!nrst)
					cpu_reset[g] <= 1'b0;
				else
					cpu_reset[g] <= startup_req && id_onehot[g];
			end
		end
	endgenerate

	// The entry point register loads its constant once out of reset.
	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			startup_entry <= 32'h0000_0000;
		else
			startup_entry <= `ACS_STARTUP_ENTRY;
	end

endmodule

/* bench/acs_unit_monitor.sv */
// Checker for the compare-and-swap unit.
// Assumes it is bound to acs_unit.
`timescale 1ns/1ps
`include "acs_map.vh"
module acs_unit_monitor
(
	input wire        clock, nrst, mem_req, mem_we, mem_lock, mem_ack, mem_err, done, fault,
	input wire        startup_req,
	input wire [3:0]  startup_cpu_id,
	input wire [2:0]  fault_code,
	input wire [15:0] cpu_reset,
	input wire [31:0] mem_addr, startup_entry
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	sequence s_read_ack; mem_req && !mem_we && mem_ack; endsequence
	property p_wlock; mem_req || mem_we |-> mem_lock; endproperty
	a_wlock: assert property (p_wlock) else $error("access without lock");
	property p_hold; mem_req && !mem_ack && !mem_err |=> mem_req && $stable(mem_addr); endproperty
	a_hold: assert property (p_hold) else $error("request dropped");
	property p_ram; mem_req |-> mem_addr >= `ACS_RAM_BASE && mem_addr <= `ACS_RAM_LIMIT; endproperty
	a_ram: assert property (p_ram) else $error("access outside RAM");
	property p_align; mem_req |-> mem_addr[1:0] == 2'h0; endproperty
	a_align: assert property (p_align) else $error("unaligned access");
	property p_next; s_read_ack |-> ##[1:2] (mem_we || done); endproperty
	a_next: assert property (p_next) else $error("no end after read");
	property p_code; fault |-> done && fault_code inside {[3'h1:3'h4]}; endproperty
	a_code: assert property (p_code) else $error("bad fault code");
	property p_pulse; done |=> !done; endproperty
	a_pulse: assert property (p_pulse) else $error("done too long");
	property p_boot; startup_req |=> cpu_reset == (16'h1 << $past(startup_cpu_id)); endproperty
	a_boot: assert property (p_boot) else $error("wrong processor reset");
	property p_entry; $past(nrst) |-> startup_entry == `ACS_STARTUP_ENTRY; endproperty
	a_entry: assert property (p_entry) else $error("wrong entry point");
endmodule

/* bench/acs_mem_model.sv */
// Behavioural memory: one word, adjustable wait, optional bus error.
// Assumes the unit holds each request until answered.
`timescale 1ns/1ps
module acs_mem_model
(
	input wire        clock, nrst, mem_req, mem_we, fail, wfail,
	input wire [3:0]  lat,
	input wire [31:0] mem_addr, mem_wdata,
	output reg        mem_ack, mem_err,
	output reg [31:0] mem_rdata
);
	reg [31:0] word;      // The one stored word.
	reg [31:0] addr_seen; // Address of the last access answered.
	reg [3:0]  cnt;       // Wait states counted so far.
	integer    writes;    // Stores that landed.
	wire       err_now = fail || (wfail && mem_we); // Error planned for this access.
	// Read data toggles when idle so stale values never look valid.
	always @(posedge clock or negedge nrst)
		if (!nrst) begin mem_ack <= 0; mem_err <= 0; cnt <= 0; mem_rdata <= 0; writes <= 0; end
		else begin
			mem_ack <= 0; mem_err <= 0; mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack && !mem_err)
				if (cnt != lat) cnt <= cnt + 1;
				else begin
					cnt <= 0; mem_err <= err_now; mem_ack <= !err_now; addr_seen <= mem_addr;
					if (!err_now && !mem_we) mem_rdata <= word;
					if (!err_now && mem_we) begin word <= mem_wdata; writes <= writes + 1; end
				end
		end
endmodule

/* bench/acs_unit_tb.sv */
// Self-checking bench for the compare-and-swap unit.
// Assumes the unit, its checker and the memory model.
`timescale 1ns/1ps
`include "acs_map.vh"
module acs_unit_tb;
	reg        clock = 0, nrst = 0, start = 0, sreq = 0, miss = 0, nw = 0, fail = 0, wfail = 0;
	reg [31:0] a = 0, e = 0, n = 0;
	reg [3:0]  id = 0, lat = 0;
	wire       mem_req, mem_we, mem_lock, mem_ack, mem_err, done, fault, busy;
	wire [31:0] mem_addr, mem_wdata, mem_rdata, result, startup_entry;
	wire [2:0]  fault_code;
	wire [15:0] cpu_reset;
	integer    fails = 0, check_count = 0, w, i, k;
	acs_unit uut (.clock, .nrst, .start, .address_operand_reg(a), .expected_value_reg(e),
		.new_value_reg(n), .store_translation_miss(miss), .page_not_writable(nw), .mem_req,
		.mem_we, .mem_lock, .mem_addr, .mem_wdata, .mem_ack, .mem_err, .mem_rdata, .done,
		.result, .fault, .fault_code, .busy, .startup_req(sreq), .startup_cpu_id(id),
		.cpu_reset, .startup_entry);
	acs_mem_model mem (.clock, .nrst, .mem_req, .mem_we, .fail, .wfail, .lat, .mem_addr, .mem_wdata,
		.mem_ack, .mem_err, .mem_rdata);
	initial forever #4 clock = ~clock;
	task check(input [31:0] got, exp);
		check_count++;
		if (got !== exp) begin fails++; $display("MISMATCH t=%0t got %h want %h", $time, got, exp); end
	endtask
	task give_verdict;
		$display("fails=%0d checks=%0d", fails, check_count);
		if (fails == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// f is {write-only bus error, bus error, not writable, store miss};
	// address bits pick the memory wait.
	task cas(input [31:0] ad, init, ex, nv, input [3:0] f, input [2:0] fc,
		input [31:0] res, fin);
		reg bz;
		bz = (fc == 0 || fc == 3) && ad >= `ACS_RAM_BASE && ad <= `ACS_RAM_LIMIT;
		mem.word = init;
		w = mem.writes;
		@(posedge clock); a <= ad; e <= ex; n <= nv; start <= 1; {wfail, fail, nw, miss} <= f;
		lat <= {1'b0, ad[4:2]};
		@(posedge clock); start <= 0;
		#1 i = 0;
		check(busy, bz);
		while (done !== 1'b1 && i < 40) begin @(posedge clock); #1 i++; end
		check(done, 1);
		check(busy, 0);
		check(fault, fc != 0);
		check(fault_code, fc);
		if (fc == 0 || fc == 3) check(result, res);
		if (bz) check(mem.addr_seen, ad);
		check(mem.word, fin);
		check(mem.writes - w, fin != init);
	endtask
	task t_swap;
		cas(32'h2000_0010, 5, 5, 9, 0, 0, 1, 9);
		cas(32'h2000_0000, 9, 9, 7, 3'h4, 3'h3, 1, 9);
		cas(32'h2000_0004, 9, 5, 7, 0, 0, 0, 9);
	endtask
	task t_place;
		cas(32'h1000_0400, 5, 5, 7, 0, 0, 0, 5);
		cas(32'h2fff_fffc, 5, 5, 7, 0, 0, 1, 7);
		cas(32'h3000_0000, 7, 7, 3, 0, 0, 0, 7);
	endtask
	task t_fault;
		cas(32'h2000_0002, 7, 7, 3, 3'h3, 3'h4, 0, 7);
		cas(32'h2000_0008, 7, 7, 3, 3'h3, 3'h1, 0, 7);
		cas(32'h2000_0008, 7, 7, 3, 3'h2, 3'h2, 0, 7);
		cas(32'h2000_0008, 7, 7, 3, 0, 0, 1, 3);
		cas(32'h2000_000c, 4, 4, 6, 4'h8, 3'h3, 1, 4);
	endtask
	// Reset lands while a swap waits on memory; busy, request, lock, done, fault, result and entry point must fall back to zero.
	task t_reset;
		@(posedge clock); a <= 32'h2000_001c; e <= 0; n <= 0; start <= 1; {wfail, fail, nw, miss} <= 0;
		lat <= 4'h7;
		@(posedge clock); start <= 0;
		#1 check(busy, 1);
		check(mem_lock, 1);
		@(posedge clock); nrst <= 0;
		#1 check({busy, mem_req, mem_lock, done, fault}, 0);
		check(result, 0);
		check(startup_entry, 0);
		@(posedge clock); nrst <= 1;
		cas(32'h2000_001c, 2, 2, 8, 0, 0, 1, 8);
	endtask
	task t_boot;
		for (k = 0; k < 16; k += 5) begin
			@(posedge clock); sreq <= 1; id <= k[3:0];
			@(posedge clock); sreq <= 0;
			#1 check(cpu_reset, 16'h1 << k);
			check(startup_entry, `ACS_STARTUP_ENTRY);
		end
		@(posedge clock);
		#1 check(cpu_reset, 0);
	endtask
	initial begin
		repeat (3) @(posedge clock);
		nrst <= 1;
		t_swap; t_place; t_fault; t_reset; t_boot;
		give_verdict;
	end
	initial begin #20000; fails++; give_verdict; end
endmodule
bind acs_unit acs_unit_monitor mon (.clock, .nrst, .mem_req, .mem_we, .mem_lock, .mem_ack,
	.mem_err, .done, .fault, .startup_req, .startup_cpu_id, .fault_code, .cpu_reset,
	.mem_addr, .startup_entry);
